// [hw/utd_usart_tx.sv]
`timescale 1ns/1ps
// Function
// R1: One holding word ahead of shift register
// R2: Two-deep receive buffer behind receive shifter
// R3: Baud tick from core or external clock
// R4: Enabled mode owns all engine resources
// R5: Data register write starts transmission
// R6: Load shifter only when it is empty
// R7: Each shifter load sends one frame
// R8: Done flag after stop, nothing pending; irq
// R9: Writer writes only while holding empty; here a write while full overwrites the holding word
// R10: Holding-empty flag follows empty holding buffer
// R11: DMA request while holding buffer empty
// R12: DMA request drops on data write
// R13: Done flag cleared by one or write
// R14: Start low, 8 bits LSB first, stop high
module utd_usart_tx (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_ext_clk_tick,
   input wire logic i_rxd,
   output logic o_txd,
   output logic o_dma_tx_req,
   output logic o_irq
);
   // One flat state word: control, divider, transmit holding word and shifter,
   // flags, a two-word receive buffer with its sampler, and the bus answer.
   // The transmit path has exactly one holding word, so a writer that ignores
   // the holding-empty flag replaces the waiting byte instead of queueing it.
   // Nothing runs unless the engine is enabled in the asynchronous mode.

   typedef struct packed {
      logic [3:0] ctrl;
      logic [15:0] baud;
      logic [15:0] bcnt;
      logic [7:0] hold;
      logic hold_full;
      utd_pkg::utd_tx_e txst;
      logic [9:0] tsh;
      logic [3:0] tcnt;
      logic txd;
      logic [3:0] flags;
      logic [3:0] ien;
      logic [7:0] rxb0;
      logic [7:0] rxb1;
      logic [1:0] rx_n;
      logic rx_act;
      logic [15:0] rx_bc;
      logic [3:0] rx_cnt;
      logic [7:0] rsh;
      logic ack;
      logic [31:0] rdata;
   } utd_state_s;

   utd_state_s st_reg;
   utd_state_s st_next;

   // Sampling mid-bit: half the baud divisor
   function automatic logic [15:0] half_of(input logic [15:0] v);
      half_of = {1'b0, v[15:1]};
   endfunction : half_of

   // Frame image, bit 0 first on the line: start low, data LSB first, stop high
   function automatic logic [9:0] frame_of(input logic [7:0] data);
      frame_of = {1'b1, data, 1'b0};
   endfunction : frame_of

   // Four-bit registers read back zero-extended to the bus width
   function automatic logic [31:0] zx4(input logic [3:0] v);
      zx4 = {28'h0000000, v};
   endfunction : zx4

   logic tick;
   logic mode_async;
   logic wr_hit;
   logic rd_hit;
   // Done flag set this cycle; a same-cycle write-one clear must lose to it
   logic txc_set;
   // Receive buffer requests, applied together after the bus decode
   logic rx_push;
   logic rx_pop;

   // Combinational next-state
   always_comb begin
      st_next = st_reg;
      txc_set = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      // One wait state: the answer comes in the cycle after the request
      st_next.ack = (i_avs_read || i_avs_write) && !st_reg.ack;
      // R4: engine serves the selected mode only
      mode_async = st_reg.ctrl[utd_pkg::CTRL_EN_BIT]
         && (st_reg.ctrl[utd_pkg::CTRL_MODE_LSB +: 2] == utd_pkg::UTD_MODE_ASYNC);
      // R3: baud source select
      // The external tick is used as it comes, one bit per pulse; the
      // internal divider reloads from the baud register at every tick
      tick = 1'b0;
      if (st_reg.ctrl[utd_pkg::CTRL_EXTCLK_BIT]) begin
         tick = i_ext_clk_tick;
      end else if (mode_async) begin
         if (st_reg.bcnt == 16'h0000) begin
            tick = 1'b1;
            st_next.bcnt = st_reg.baud;
         end else begin
            st_next.bcnt = st_reg.bcnt - 16'h0001;
         end
      end
      tick = tick && mode_async;
      // Writes commit at the edge where waitrequest is seen low
      wr_hit = i_avs_write && st_reg.ack;
      rd_hit = i_avs_read && !st_reg.ack;

      // Transmit shifter; frame bit 0 is start
      case (st_reg.txst)
         utd_pkg::UTD_TX_IDLE: begin
            st_next.txd = 1'b1;
            // R6: move holding word only into empty shifter
            if (st_reg.hold_full && mode_async) begin
               // R14: start low, data LSB first, stop high
               st_next.tsh = frame_of(st_reg.hold);
               st_next.tcnt = utd_pkg::FRAME_BITS;
               st_next.hold_full = 1'b0;
               st_next.txst = utd_pkg::UTD_TX_SHIFT;
               // Restart the divider so the start bit lasts a whole bit time
               st_next.bcnt = st_reg.baud;
               st_next.txd = 1'b0;
            end
         end
         utd_pkg::UTD_TX_SHIFT: begin
            if (!mode_async) begin
               // Leaving the mode drops the frame and frees the line
               st_next.txst = utd_pkg::UTD_TX_IDLE;
               st_next.txd = 1'b1;
            // R7: one complete frame per load
            end else if (tick) begin
               if (st_reg.tcnt == 4'h1) begin
                  st_next.txst = utd_pkg::UTD_TX_IDLE;
                  st_next.txd = 1'b1;
                  // R8: done after stop when nothing waits
                  if (!st_reg.hold_full) begin
                     st_next.flags[utd_pkg::FLG_TX_DONE] = 1'b1;
                     txc_set = 1'b1;
                  end
               end else begin
                  st_next.tsh = {1'b1, st_reg.tsh[9:1]};
                  st_next.txd = st_reg.tsh[1];
               end
               st_next.tcnt = st_reg.tcnt - 4'h1;
            end
         end
         default: begin
            st_next.txst = utd_pkg::UTD_TX_IDLE;
         end
      endcase

      // Receiver: oversample on core clock, mid-bit sampling
      // A low line starts a half-bit wait, then one sample per bit time.
      // Only the internal divider paces the receiver; the stop bit is not
      // checked, a damaged frame is still queued.
      if (!mode_async) begin
         st_next.rx_act = 1'b0;
      end else if (!st_reg.rx_act) begin
         if (!i_rxd) begin
            st_next.rx_act = 1'b1;
            st_next.rx_bc = half_of(st_reg.baud);
            st_next.rx_cnt = 4'h0;
         end
      end else if (st_reg.rx_bc != 16'h0000) begin
         st_next.rx_bc = st_reg.rx_bc - 16'h0001;
      end else begin
         st_next.rx_bc = st_reg.baud;
         st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
         if (st_reg.rx_cnt == 4'h0 && i_rxd) begin
            st_next.rx_act = 1'b0; // False start
         end else if (st_reg.rx_cnt == 4'(utd_pkg::DATA_BITS + 1)) begin
            st_next.rx_act = 1'b0;
            // R2: stop bit reached; the byte is queued below
            rx_push = 1'b1;
         end else if (st_reg.rx_cnt != 4'h0) begin
            st_next.rsh = {i_rxd, st_reg.rsh[7:1]};
         end
      end

      // Register access, one wait state
      // Reads are captured when the request first appears so the data
      // stands through the answering cycle; writes land one edge later,
      // together with the answer, so a master that is still waiting
      // never sees a half-finished write.
      if (wr_hit) begin
         case (i_avs_address)
            5'(utd_pkg::CTRL_OFS): st_next.ctrl = i_avs_writedata[3:0];
            5'(utd_pkg::BAUD_OFS): st_next.baud = i_avs_writedata[15:0];
            5'(utd_pkg::DATA_OFS): begin
               // R9: writes while full overwrite the holding word
               // R5: a data write starts transmission
               st_next.hold = i_avs_writedata[7:0];
               st_next.hold_full = 1'b1;
               // R13: new data clears the done flag
               st_next.flags[utd_pkg::FLG_TX_DONE] = 1'b0;
            end
            utd_pkg::FCLR_OFS: begin
               // R13: write one to clear; a same-cycle set wins
               if (i_avs_writedata[utd_pkg::FLG_TX_DONE] && !txc_set) begin
                  st_next.flags[utd_pkg::FLG_TX_DONE] = 1'b0;
               end
               if (i_avs_writedata[utd_pkg::FLG_OVF]) begin
                  st_next.flags[utd_pkg::FLG_OVF] = 1'b0;
               end
            end
            utd_pkg::IEN_OFS: st_next.ien = i_avs_writedata[3:0];
            default: ;
         endcase
      end
      if (rd_hit) begin
         st_next.rdata = 32'h0000_0000;
         case (i_avs_address)
            5'(utd_pkg::CTRL_OFS): st_next.rdata = zx4(st_reg.ctrl);
            5'(utd_pkg::BAUD_OFS): st_next.rdata = {16'h0, st_reg.baud};
            utd_pkg::FLAG_OFS: st_next.rdata = zx4(st_reg.flags);
            utd_pkg::IEN_OFS: st_next.rdata = zx4(st_reg.ien);
            utd_pkg::RXD_OFS: begin
               st_next.rdata = {24'h0, st_reg.rxb0};
               // Reading pops the oldest word; an empty buffer is left alone
               rx_pop = (st_reg.rx_n != 2'h0);
            end
            default: ; // Unmapped reads return zero
         endcase
      end
      // R2: apply receive-buffer push and pop in one place.
      // A push into a full buffer only raises overflow, so software keeps
      // the two oldest words; a pop in the same cycle makes room first,
      // which is why both requests are decoded together here.
      case ({rx_push, rx_pop})
         2'b10: begin
            if (st_reg.rx_n == 2'h2) begin
               st_next.flags[utd_pkg::FLG_OVF] = 1'b1;
            end else if (st_reg.rx_n == 2'h1) begin
               st_next.rxb1 = st_reg.rsh;
               st_next.rx_n = 2'h2;
            end else begin
               st_next.rxb0 = st_reg.rsh;
               st_next.rx_n = 2'h1;
            end
         end
         2'b01: begin
            // Oldest word leaves, the younger one moves to the front
            st_next.rxb0 = st_reg.rxb1;
            st_next.rx_n = st_reg.rx_n - 2'h1;
         end
         2'b11: begin
            // Pop and push together keep the count unchanged
            if (st_reg.rx_n == 2'h2) begin
               st_next.rxb0 = st_reg.rxb1;
               st_next.rxb1 = st_reg.rsh;
            end else begin
               st_next.rxb0 = st_reg.rsh;
            end
         end
         default: ;
      endcase

      // R10: holding-empty flag tracks the buffer
      st_next.flags[utd_pkg::FLG_HOLD_EMPTY] = !st_next.hold_full;
      st_next.flags[utd_pkg::FLG_RXC] = (st_next.rx_n != 2'd0);
   end

   // State register
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
         st_reg.ctrl <= utd_pkg::CTRL_RST;
         st_reg.baud <= utd_pkg::BAUD_RST;
         st_reg.txd <= 1'b1;
         st_reg.tsh <= 10'h3FF;
         st_reg.flags <= 4'h1;
         st_reg.txst <= utd_pkg::UTD_TX_IDLE;
         // Empty buffers and an idle sampler, so nothing is queued at start
         st_reg.hold_full <= 1'b0;
         st_reg.rx_n <= 2'h0;
         st_reg.rx_act <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs
   // Waitrequest is combinational so the first cycle of a request is
   // always held; every other output comes straight from the state word
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_reg.ack;
   assign o_avs_readdata = st_reg.rdata;
   // R14: line idles high
   assign o_txd = st_reg.txd;
   // R11: request while holding buffer empty
   // R12: drops the cycle after a data write
   assign o_dma_tx_req = !st_reg.hold_full;
   // R8: level interrupt from enabled flags
   assign o_irq = |(st_reg.flags & st_reg.ien);
endmodule : utd_usart_tx

// [pkg/utd_pkg.sv]
package utd_pkg;
   // Register byte offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] BAUD_OFS = 4'h4;
   localparam logic [3:0] DATA_OFS = 4'h8;
   localparam logic [3:0] STAT_OFS = 4'hC;
   localparam logic [3:0] CLR_OFS = 4'h0 + 4'h0;
   // Bank of the flag group sits at offset 0x10 and above
   localparam logic [4:0] FLAG_OFS = 5'h10;
   localparam logic [4:0] FCLR_OFS = 5'h14;
   localparam logic [4:0] IEN_OFS = 5'h18;
   localparam logic [4:0] RXD_OFS = 5'h1C;
   // Control field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_EXTCLK_BIT = 1;
   localparam int CTRL_MODE_LSB = 2;
   // Flag positions
   localparam int FLG_HOLD_EMPTY = 0;
   localparam int FLG_TX_DONE = 1;
   localparam int FLG_RXC = 2;
   localparam int FLG_OVF = 3;
   localparam int FLG_W = 4;
   // Reset values
   localparam logic [15:0] BAUD_RST = 16'h0001;
   localparam logic [3:0] CTRL_RST = 4'h0;
   // Frame shape: start + 8 data + stop
   localparam int DATA_BITS = 8;
   localparam logic [3:0] FRAME_BITS = 4'hA;
   // Engine modes; only the serial-async mode drives the line
   typedef enum logic [1:0] {
      UTD_MODE_OFF = 2'b00,
      UTD_MODE_ASYNC = 2'b01,
      UTD_MODE_SPI = 2'b10,
      UTD_MODE_TWI = 2'b11
   } utd_mode_e;
   typedef enum logic [1:0] {
      UTD_TX_IDLE = 2'b00,
      UTD_TX_SHIFT = 2'b01
   } utd_tx_e;
   // Avalon-MM request bundle
   typedef struct packed {
      logic [4:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } utd_av_req_s;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } utd_av_rsp_s;
endpackage : utd_pkg

// [tb/utd_usart_tx_checker.sv]
`timescale 1ns/1ps
// Port-level checks of bus answer, request, line and interrupt
module utd_usart_tx_checker (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_ext_clk_tick,
   input wire logic i_rxd,
   input wire logic o_txd,
   input wire logic o_dma_tx_req,
   input wire logic o_irq
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   logic dwr;
   logic req;
   // Taken data write; bit checks assume the reset baud of two cycles
   assign dwr = i_avs_write && !o_avs_waitrequest && i_avs_address == 5'h08;
   assign req = i_avs_read || i_avs_write;
   a_wait_first: assert property (req && !$past(req) |-> o_avs_waitrequest)
      else $error("no wait state");
   a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("answer late");
   a_req_drop: assert property (dwr |=> !o_dma_tx_req)
      else $error("request kept");
   a_req_cause: assert property ($fell(o_dma_tx_req) |-> $past(dwr))
      else $error("request lost");
   a_hold_full: assert property (dwr && !o_dma_tx_req |=> !o_dma_tx_req)
      else $error("second slot");
   a_start_hold: assert property ($fell(o_txd) |=> !o_txd)
      else $error("short start");
   a_bit_hold: assert property ($changed(o_txd) |=> $stable(o_txd))
      else $error("short bit");
   a_irq_cause: assert property ($rose(o_irq) |-> o_dma_tx_req)
      else $error("irq while full");
endmodule : utd_usart_tx_checker

bind utd_usart_tx utd_usart_tx_checker chk (.i_core_clk, .i_rst_n, .i_avs_address,
   .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
   .i_ext_clk_tick, .i_rxd, .o_txd, .o_dma_tx_req, .o_irq);

// [tb/utd_line_rx.sv]
`timescale 1ns/1ps
// Remote receiver; bit time is fixed, it cannot follow a baud change
module utd_line_rx #(
   parameter int BIT = 2
) (
   input wire logic i_clk,
   input wire logic i_line,
   output logic [7:0] o_byte,
   output int o_cnt
);
   logic [9:0] sh;
   initial begin
      o_cnt = 0;
      o_byte = 8'h00;
      forever begin
         @(negedge i_line);
         repeat (BIT / 2) @(posedge i_clk);
         sh[0] = i_line;
         for (int i = 1; i < 10; i++) begin
            repeat (BIT) @(posedge i_clk);
            sh[i] = i_line;
         end
         // A broken start or stop inverts the byte so it cannot match
         o_byte = (!sh[0] && sh[9]) ? sh[8:1] : ~sh[8:1];
         o_cnt++;
      end
   end
endmodule : utd_line_rx

// [tb/utd_usart_tx_bench.sv]
`timescale 1ns/1ps
// Bus master plus line receiver around the transmitter
module utd_usart_tx_bench;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [4:0] i_avs_address = 5'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest, o_txd, o_dma_tx_req, o_irq;
   logic [7:0] rx_byte;
   logic [31:0] rd;
   int rx_cnt;
   logic ext_tick = 1'b0;
   logic rx_loop = 1'b0;
   logic rxd_line;
   int seen = 0;
   int num_errors = 0;
   int total_checks = 0;
   // 250 MHz core clock
   initial begin
      forever #2 i_core_clk = ~i_core_clk;
   end
   utd_usart_tx dut (.i_core_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_ext_clk_tick(ext_tick),
      .i_rxd(rxd_line), .o_txd, .o_dma_tx_req, .o_irq);
   // Loopback feeds the receiver only while a scenario asks for it
   assign rxd_line = rx_loop ? o_txd : 1'b1;
   utd_line_rx #(.BIT(2)) rx (.i_clk(i_core_clk), .i_line(o_txd), .o_byte(rx_byte),
      .o_cnt(rx_cnt));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Holds the request until waitrequest is seen low, then releases
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      i_avs_address <= a;
      i_avs_write <= w;
      i_avs_read <= ~w;
      i_avs_writedata <= d;
      @(posedge i_core_clk);
      while (o_avs_waitrequest !== 1'b0)
         @(posedge i_core_clk);
      rd = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_core_clk);
   endtask : av
   task automatic frame(input logic [7:0] b);
      while (rx_cnt == seen)
         @(posedge i_core_clk);
      seen++;
      chk(rx_byte, b);
      repeat (4) @(posedge i_core_clk);
   endtask : frame
   task automatic t_reset();
      chk(o_dma_tx_req, 1'b1);
      chk(o_txd, 1'b1);
      chk(o_irq, 1'b0);
      av(1'b0, 5'h04, 32'h0);
      chk(rd, 32'h1);
      av(1'b0, 5'h0C, 32'h0);
      chk(rd, 32'h0);
      av(1'b1, 5'h00, 32'h5);
   endtask : t_reset
   task automatic t_flags();
      av(1'b1, 5'h08, 32'hA5);
      frame(8'hA5);
      chk(o_irq, 1'b0);
      av(1'b0, 5'h10, 32'h0);
      chk(rd, 32'h3);
      av(1'b1, 5'h18, 32'h2);
      chk(o_irq, 1'b1);
      av(1'b1, 5'h14, 32'h2);
      chk(o_irq, 1'b0);
      av(1'b1, 5'h08, 32'h3C);
      frame(8'h3C);
      chk(o_irq, 1'b1);
      av(1'b1, 5'h08, 32'hC3);
      chk(o_irq, 1'b0);
      frame(8'hC3);
      av(1'b1, 5'h18, 32'h0);
      chk(o_irq, 1'b0);
   endtask : t_flags
   // Third write lands on a full holding word and replaces it
   task automatic t_b2b();
      av(1'b1, 5'h08, 32'h11);
      av(1'b1, 5'h08, 32'h22);
      av(1'b1, 5'h08, 32'h33);
      frame(8'h11);
      frame(8'h33);
      repeat (40) @(posedge i_core_clk);
      chk(rx_cnt, seen);
   endtask : t_b2b
   // Line looped into the receiver; three frames into a two-word buffer
   task automatic t_rx();
      rx_loop <= 1'b1;
      @(posedge i_core_clk);
      for (int i = 0; i < 3; i++) begin
         av(1'b0, 5'h10, 32'h0);
         chk(rd[0], 1'b1);
         av(1'b1, 5'h08, 32'h60 + i);
         frame(8'h60 + 8'(i));
      end
      av(1'b0, 5'h10, 32'h0);
      chk(rd, 32'hF);
      av(1'b0, 5'h1C, 32'h0);
      chk(rd, 32'h60);
      av(1'b0, 5'h1C, 32'h0);
      chk(rd, 32'h61);
      av(1'b0, 5'h10, 32'h0);
      chk(rd, 32'hB);
      av(1'b1, 5'h14, 32'h8);
      av(1'b0, 5'h10, 32'h0);
      chk(rd, 32'h3);
      rx_loop <= 1'b0;
   endtask : t_rx
   // External baud: no tick holds the start bit, ten ticks finish the frame
   task automatic t_ext();
      av(1'b1, 5'h00, 32'h7);
      av(1'b1, 5'h08, 32'hFF);
      repeat (40) @(posedge i_core_clk);
      chk(o_txd, 1'b0);
      repeat (10) begin
         ext_tick <= 1'b1;
         @(posedge i_core_clk);
         ext_tick <= 1'b0;
         repeat (3) @(posedge i_core_clk);
      end
      chk(o_txd, 1'b1);
      av(1'b0, 5'h10, 32'h0);
      chk(rd[1:0], 2'h3);
      // The fixed-rate line model misreads this slow frame; skip it
      seen = rx_cnt;
      av(1'b1, 5'h00, 32'h5);
   endtask : t_ext
   task automatic t_mode();
      av(1'b1, 5'h00, 32'h1);
      av(1'b1, 5'h08, 32'h55);
      repeat (40) @(posedge i_core_clk);
      chk(rx_cnt, seen);
   endtask : t_mode
   task automatic final_report();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge i_core_clk);
      num_errors++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      t_reset();
      t_flags();
      t_b2b();
      t_rx();
      t_ext();
      t_mode();
      final_report();
   end
endmodule : utd_usart_tx_bench
